// ==== mcs_pkg.sv ====
// Notes on behaviour
// R1: Two clock-mode switches: ON/ON internal, OFF/ON external, ON/OFF recover, else reserved.
// R2: Internal mode drives serial and DSL clocks from the on-board oscillator.
// R3: External mode uses the serial interface clock to time the DSL link.
// R4: Recover mode feeds the recovered DSL clock to the serial interface.
// R5: On the Ethernet variant external clock mode is invalid.
// R6: Of two X.21 units, one recovers clock, the other is internal or external.
// R7: X.21 recover or internal units are DCE; external units are DTE.
// R8: Loop request pins start local or remote loops only when loops are enabled.
// R9: One switch selects the terminal interface: ON gives E1, OFF normal serial.
// R10: Eight switches give a 0 to 255 address, ON reads 0, eighth is MSB.
// R11: Each card holds a unique address; only the matching card is activated.
// R12: All switches OFF at power-up enters reset mode with a 19200 bps console.
// R13: In reset mode the management interface is active without address selection.
// R14: In normal operation the console runs at 9600 bps, 8N1 with XON/XOFF.
// R15: One timeslot count sets both the serial and DSL data rates.
// R16: An interval is errored when errors reach the maximum; zero disables monitoring.
// R17: After the configured number of errored intervals the DSL link restarts.
// R18: Monitoring starts a configured number of seconds after the link comes up.
// R19: The monitor stops after the configured total number of intervals.
// R20: Sync state: out of sync, acquiring, in sync, losing sync.
// R21: Link state: in progress, success, deactivated, idle.
// R22: Counters for CRC, sync loss, TX FIFO full/empty/slip, stuffing, RX FIFO.
// R23: A total interval count of zero keeps the monitor running forever.
// R24: Errors equal to the threshold already make the interval errored.
package mcs_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_RESET = 19200;
  localparam int BAUD_NORMAL = 9600;
  localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_HZ / BAUD_RESET);
  localparam logic [15:0] BAUD_DIV_NORMAL = 16'(CLK_HZ / BAUD_NORMAL);
  localparam int SEC_NS = 1_000_000_000;
  localparam int CLK_NS = 10;
  localparam int SEC_CYCLES_DEF = SEC_NS / CLK_NS;
  localparam logic [2:0] OSC_HALF_CYCLES = 3'h4;
  localparam logic [1:0] BOOT_SETTLE = 2'h3;
  localparam logic [2:0] SYNC_CONFIRM = 3'h4;

  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_TIMESLOTS = 12'h008;
  localparam logic [11:0] OFS_EM_MAXERR = 12'h00c;
  localparam logic [11:0] OFS_EM_INTTIME = 12'h010;
  localparam logic [11:0] OFS_EM_INTCNT = 12'h014;
  localparam logic [11:0] OFS_EM_TOTINT = 12'h018;
  localparam logic [11:0] OFS_EM_DELAY = 12'h01c;
  localparam logic [11:0] OFS_EM_STATUS = 12'h020;
  localparam logic [11:0] OFS_CNT_BASE = 12'h040;
  localparam int NUM_CNT = 9;

  localparam int CTRL_LINK_EN = 0;
  localparam int CTRL_CLR_CNT = 1;
  localparam int CTRL_RESTART = 2;
  localparam logic RST_LINK_EN = 1'b1;
  localparam logic [6:0] RST_TIMESLOTS = 7'h01;
  localparam logic [15:0] RST_EM_MAXERR = 16'h0000;
  localparam logic [15:0] RST_EM_INTTIME = 16'h0001;
  localparam logic [7:0] RST_EM_INTCNT = 8'h01;
  localparam logic [15:0] RST_EM_TOTINT = 16'h0000;
  localparam logic [15:0] RST_EM_DELAY = 16'h0000;

  // Counter slots; slot 1 counts losses of sync word.
  localparam int CNT_CRC = 0;
  localparam int CNT_SYNC_LOSS = 1;

  // Switch bit positions within the second switch bank.
  localparam int SW_CLK_A = 3;
  localparam int SW_CLK_B = 4;
  localparam int SW_LOOPS = 5;
  localparam int SW_IFTYPE = 6;

  // Encoded as {second clock switch, first clock switch}, OFF = 1.
  typedef enum logic [1:0] {
    CLK_INTERNAL = 2'h0,
    CLK_EXTERNAL = 2'h1,
    CLK_RECOVER = 2'h2,
    CLK_RESERVED = 2'h3
  } mcs_clk_mode_t;

  typedef enum logic [1:0] {
    LINK_IN_PROGRESS = 2'h0,
    LINK_SUCCESS = 2'h1,
    LINK_DEACTIVATED = 2'h2,
    LINK_IDLE = 2'h3
  } mcs_link_t;

  typedef enum logic [3:0] {
    SY_OUT = 4'h1,
    SY_ACQ = 4'h2,
    SY_IN = 4'h4,
    SY_LOSE = 4'h8
  } mcs_sync_t;

  typedef enum logic [3:0] {
    EM_OFF = 4'h1,
    EM_DELAY = 4'h2,
    EM_RUN = 4'h4,
    EM_DONE = 4'h8
  } mcs_em_t;

  // Pins from outside the pclk domain; switches read 1 when OFF.
  typedef struct packed {
    logic [7:0] sw1;
    logic [7:0] sw2;
    logic [7:0] sw3;
    logic ser_clk;
    logic dsl_rx_clk;
    logic local_loop_request;
    logic remote_loop_request;
    logic eth_variant;
    logic [7:0] chassis_addr;
    logic chassis_sel;
  } mcs_pins_t;

  // Events and levels from the DSL core, on pclk.
  typedef struct packed {
    logic [7:0] err_evt;
    logic sw_found;
    logic sw_error;
    logic training;
    logic linked;
  } mcs_dsl_t;

  typedef struct packed {
    mcs_pins_t meta;
    mcs_pins_t pins;
    logic [1:0] boot_cnt;
    logic boot_done;
    logic reset_mode;
    logic [2:0] osc_cnt;
    logic osc_clk;
    logic ser_clk_out;
    logic dsl_clk_out;
    mcs_clk_mode_t clk_mode;
    logic clk_invalid;
    logic loc_loop;
    logic rem_loop;
    logic if_e1;
    logic [7:0] mgmt_addr;
    logic mgmt_active;
    logic [15:0] baud_div;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic link_en;
    logic [6:0] timeslots;
    logic [15:0] max_err;
    logic [15:0] int_time;
    logic [7:0] int_cnt;
    logic [15:0] tot_int;
    logic [15:0] start_delay;
    mcs_em_t em_st;
    logic [31:0] sec_cnt;
    logic [15:0] sec_in;
    logic [15:0] int_errs;
    logic [7:0] bad_ints;
    logic [15:0] ints_done;
    logic restart;
    mcs_sync_t sync_st;
    logic [2:0] sync_run;
    mcs_link_t link_st;
    logic [NUM_CNT-1:0][15:0] cnt;
  } mcs_state_t;

endpackage

// ==== mcs_top.sv ====
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module mcs_top
  import mcs_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mcs_pins_t pins_i,
  input wire mcs_dsl_t dsl_i,
  output logic ser_clk_o,
  output logic dsl_clk_o,
  output mcs_clk_mode_t clk_mode_o,
  output logic clk_invalid_o,
  output logic local_loop_o,
  output logic remote_loop_o,
  output logic if_e1_o,
  output logic [7:0] mgmt_addr_o,
  output logic mgmt_active_o,
  output logic reset_mode_o,
  output logic [15:0] console_baud_div_o,
  output logic [6:0] timeslots_o,
  output logic dsl_link_enable_o,
  output logic dsl_restart_o,
  output logic [1:0] sync_state_o,
  output mcs_link_t link_state_o
);

  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

  mcs_state_t s_r;
  mcs_state_t s_nxt;

  function automatic logic [1:0] sync_code(input mcs_sync_t st);
    case (st)
      SY_ACQ: sync_code = 2'h1;
      SY_IN: sync_code = 2'h2;
      SY_LOSE: sync_code = 2'h3;
      default: sync_code = 2'h0;
    endcase
  endfunction

  function automatic logic [15:0] sat_add(input logic [15:0] a,
                                          input logic inc);
    sat_add = (inc && a != 16'hffff) ? a + 16'h0001 : a;
  endfunction

  function automatic logic [3:0] pop8(input logic [7:0] v);
    pop8 = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      pop8 = pop8 + {3'h0, v[i]};
    end
  endfunction

  always_comb
  begin
    logic wr;
    logic mapped;
    logic [31:0] rd;
    logic [NUM_CNT-1:0] evt;
    logic sec_tick;
    logic sync_lost;
    logic int_end;
    logic errored;
    logic [15:0] errs_now;
    logic [7:0] bad_now;
    s_nxt = s_r;
    wr = 1'b0;
    mapped = 1'b0;
    rd = 32'h0000_0000;
    evt = '0;
    sec_tick = 1'b0;
    sync_lost = 1'b0;
    int_end = 1'b0;
    errored = 1'b0;
    errs_now = 16'h0000;
    bad_now = 8'h00;

    // Two-stage synchroniser for every pin input.
    s_nxt.meta = pins_i;
    s_nxt.pins = s_r.meta;

    // The settle delay lets the synchroniser fill before the straps
    // are judged, so a stale all-ON reset value never masks reset mode.
    if (!s_r.boot_done)
    begin
      s_nxt.boot_cnt = s_r.boot_cnt + 2'h1;
      if (s_r.boot_cnt == BOOT_SETTLE)
      begin
        s_nxt.boot_done = 1'b1;
        s_nxt.reset_mode = &{s_r.pins.sw1, s_r.pins.sw2,
                             s_r.pins.sw3}; // see R12
      end
    end
    s_nxt.baud_div = s_r.reset_mode ? BAUD_DIV_RESET
                                    : BAUD_DIV_NORMAL; // see R12, see R14

    s_nxt.clk_mode = mcs_clk_mode_t'({s_r.pins.sw2[SW_CLK_B],
                                      s_r.pins.sw2[SW_CLK_A]}); // see R1
    s_nxt.clk_invalid = (s_r.clk_mode == CLK_RESERVED) ||
      (s_r.clk_mode == CLK_EXTERNAL && s_r.pins.eth_variant); // see R5

    if (s_r.osc_cnt == OSC_HALF_CYCLES - 3'h1)
    begin
      s_nxt.osc_cnt = 3'h0;
      s_nxt.osc_clk = ~s_r.osc_clk;
    end
    else
    begin
      s_nxt.osc_cnt = s_r.osc_cnt + 3'h1;
    end

    // Clocks stand low while the mode is reserved or invalid.
    if (s_r.clk_invalid)
    begin
      s_nxt.ser_clk_out = 1'b0;
      s_nxt.dsl_clk_out = 1'b0;
    end
    else
    begin
      case (s_r.clk_mode)
        CLK_INTERNAL:
        begin
          s_nxt.ser_clk_out = s_r.osc_clk; // see R2
          s_nxt.dsl_clk_out = s_r.osc_clk; // see R2
        end
        CLK_EXTERNAL:
        begin
          s_nxt.ser_clk_out = 1'b0;
          s_nxt.dsl_clk_out = s_r.pins.ser_clk; // see R3
        end
        CLK_RECOVER:
        begin
          s_nxt.ser_clk_out = s_r.pins.dsl_rx_clk; // see R4
          s_nxt.dsl_clk_out = s_r.pins.dsl_rx_clk;
        end
        default:
        begin
          s_nxt.ser_clk_out = 1'b0;
          s_nxt.dsl_clk_out = 1'b0;
        end
      endcase
    end

    s_nxt.loc_loop = ~s_r.pins.sw2[SW_LOOPS] &&
                     s_r.pins.local_loop_request; // see R8
    s_nxt.rem_loop = ~s_r.pins.sw2[SW_LOOPS] &&
                     s_r.pins.remote_loop_request; // see R8
    s_nxt.if_e1 = ~s_r.pins.sw2[SW_IFTYPE]; // see R9
    s_nxt.mgmt_addr = s_r.pins.sw3; // see R10
    s_nxt.mgmt_active = s_r.reset_mode ||
      (s_r.pins.chassis_sel &&
       s_r.pins.chassis_addr == s_r.mgmt_addr); // see R11, see R13

    if (!s_r.link_en)
    begin
      s_nxt.link_st = LINK_DEACTIVATED; // see R21
    end
    else if (dsl_i.linked)
    begin
      s_nxt.link_st = LINK_SUCCESS;
    end
    else if (dsl_i.training)
    begin
      s_nxt.link_st = LINK_IN_PROGRESS;
    end
    else
    begin
      s_nxt.link_st = LINK_IDLE;
    end

    // Sync tracking; found and error in one cycle counts as an error.
    case (s_r.sync_st) // see R20
      SY_OUT:
      begin
        if (dsl_i.sw_found && !dsl_i.sw_error)
        begin
          s_nxt.sync_st = SY_ACQ;
          s_nxt.sync_run = 3'h1;
        end
      end
      SY_ACQ:
      begin
        if (dsl_i.sw_error)
        begin
          s_nxt.sync_st = SY_OUT;
        end
        else if (dsl_i.sw_found)
        begin
          s_nxt.sync_run = s_r.sync_run + 3'h1;
          if (s_r.sync_run == SYNC_CONFIRM - 3'h1)
          begin
            s_nxt.sync_st = SY_IN;
          end
        end
      end
      SY_IN:
      begin
        if (dsl_i.sw_error)
        begin
          s_nxt.sync_st = SY_LOSE;
          s_nxt.sync_run = 3'h1;
        end
      end
      SY_LOSE:
      begin
        if (dsl_i.sw_error)
        begin
          s_nxt.sync_run = s_r.sync_run + 3'h1;
          if (s_r.sync_run == SYNC_CONFIRM - 3'h1)
          begin
            s_nxt.sync_st = SY_OUT;
            sync_lost = 1'b1;
          end
        end
        else if (dsl_i.sw_found)
        begin
          s_nxt.sync_st = SY_IN;
        end
      end
      default:
      begin
        s_nxt.sync_st = SY_OUT;
      end
    endcase

    // Error monitor: seconds from a free counter restarted on entry.
    s_nxt.restart = 1'b0;
    if (s_r.sec_cnt == SEC_LAST)
    begin
      s_nxt.sec_cnt = 32'h0;
      sec_tick = 1'b1;
    end
    else
    begin
      s_nxt.sec_cnt = s_r.sec_cnt + 32'h1;
    end
    case (s_r.em_st)
      EM_OFF:
      begin
        if (s_r.link_st != LINK_SUCCESS && s_nxt.link_st == LINK_SUCCESS &&
            s_r.max_err != 16'h0000) // see R16
        begin
          s_nxt.em_st = EM_DELAY; // see R18
          s_nxt.sec_cnt = 32'h0;
          s_nxt.sec_in = 16'h0000;
          s_nxt.bad_ints = 8'h00;
          s_nxt.ints_done = 16'h0000;
        end
      end
      EM_DELAY:
      begin
        if (s_r.sec_in >= s_r.start_delay)
        begin
          s_nxt.em_st = EM_RUN; // see R18
          s_nxt.sec_in = 16'h0000;
          s_nxt.int_errs = 16'h0000;
        end
        else if (sec_tick)
        begin
          s_nxt.sec_in = s_r.sec_in + 16'h0001;
        end
      end
      EM_RUN:
      begin
        errs_now = s_r.int_errs + {12'h000, pop8(dsl_i.err_evt)};
        if (errs_now < s_r.int_errs)
        begin
          errs_now = 16'hffff;
        end
        s_nxt.int_errs = errs_now;
        if (sec_tick)
        begin
          s_nxt.sec_in = s_r.sec_in + 16'h0001;
          int_end = (s_r.sec_in + 16'h0001 >= s_r.int_time); // see R17
        end
        if (int_end)
        begin
          errored = (errs_now >= s_r.max_err); // see R16, see R24
          bad_now = s_r.bad_ints + {7'h00, errored};
          s_nxt.bad_ints = bad_now;
          s_nxt.ints_done = s_r.ints_done + 16'h0001;
          s_nxt.sec_in = 16'h0000;
          s_nxt.int_errs = 16'h0000;
          if (errored && bad_now >= s_r.int_cnt)
          begin
            s_nxt.restart = 1'b1; // see R17
            s_nxt.em_st = EM_OFF;
          end
          else if (s_r.tot_int != 16'h0000 &&
                   s_r.ints_done + 16'h0001 == s_r.tot_int) // see R19, see R23
          begin
            s_nxt.em_st = EM_DONE;
          end
        end
      end
      EM_DONE:
      begin
      end
      default:
      begin
        s_nxt.em_st = EM_OFF;
      end
    endcase
    if (s_r.em_st != EM_OFF && s_r.link_st != LINK_SUCCESS)
    begin
      s_nxt.em_st = EM_OFF;
    end

    // Register read data is prepared in the setup cycle.
    case (paddr)
      OFS_CTRL: rd = {29'h0, 2'h0, s_r.link_en};
      OFS_STATUS: rd = {8'h0, s_r.mgmt_addr, 2'h0, s_r.link_st,
                        sync_code(s_r.sync_st), s_r.clk_invalid,
                        s_r.clk_mode, s_r.reset_mode, s_r.mgmt_active,
                        s_r.if_e1, s_r.rem_loop, s_r.loc_loop};
      OFS_TIMESLOTS: rd = {25'h0, s_r.timeslots};
      OFS_EM_MAXERR: rd = {16'h0, s_r.max_err};
      OFS_EM_INTTIME: rd = {16'h0, s_r.int_time};
      OFS_EM_INTCNT: rd = {24'h0, s_r.int_cnt};
      OFS_EM_TOTINT: rd = {16'h0, s_r.tot_int};
      OFS_EM_DELAY: rd = {16'h0, s_r.start_delay};
      OFS_EM_STATUS: rd = {s_r.ints_done, s_r.bad_ints, 4'h0, s_r.em_st};
      default: rd = 32'h0;
    endcase
    mapped = (paddr <= OFS_EM_STATUS) && (paddr[1:0] == 2'h0);
    for (int i = 0; i < NUM_CNT; i++)
    begin
      if (paddr == OFS_CNT_BASE + 12'(4 * i))
      begin
        mapped = 1'b1;
        rd = {16'h0, s_r.cnt[i]};
      end
    end
    s_nxt.pready = psel && !penable;
    s_nxt.pslverr = psel && !penable && !mapped;
    s_nxt.prdata = (psel && !penable && !pwrite && mapped) ? rd : 32'h0;

    wr = psel && penable && s_r.pready && pwrite && !s_r.pslverr;
    if (wr)
    begin
      case (paddr)
        OFS_CTRL:
        begin
          s_nxt.link_en = pwdata[CTRL_LINK_EN];
          if (pwdata[CTRL_RESTART])
          begin
            s_nxt.restart = 1'b1;
          end
        end
        OFS_TIMESLOTS: s_nxt.timeslots = pwdata[6:0]; // see R15
        OFS_EM_MAXERR: s_nxt.max_err = pwdata[15:0];
        OFS_EM_INTTIME: s_nxt.int_time = pwdata[15:0];
        OFS_EM_INTCNT: s_nxt.int_cnt = pwdata[7:0];
        OFS_EM_TOTINT: s_nxt.tot_int = pwdata[15:0];
        OFS_EM_DELAY: s_nxt.start_delay = pwdata[15:0];
        default:
        begin
        end
      endcase
    end

    // A counter event in the clearing cycle still counts once.
    evt = {dsl_i.err_evt[7:1], sync_lost, dsl_i.err_evt[CNT_CRC]};
    for (int i = 0; i < NUM_CNT; i++)
    begin
      if (wr && paddr == OFS_CTRL && pwdata[CTRL_CLR_CNT])
      begin
        s_nxt.cnt[i] = {15'h0, evt[i]}; // see R22
      end
      else
      begin
        s_nxt.cnt[i] = sat_add(s_r.cnt[i], evt[i]); // see R22
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.baud_div <= BAUD_DIV_NORMAL;
      s_r.clk_mode <= CLK_INTERNAL;
      s_r.link_en <= RST_LINK_EN;
      s_r.timeslots <= RST_TIMESLOTS;
      s_r.max_err <= RST_EM_MAXERR;
      s_r.int_time <= RST_EM_INTTIME;
      s_r.int_cnt <= RST_EM_INTCNT;
      s_r.tot_int <= RST_EM_TOTINT;
      s_r.start_delay <= RST_EM_DELAY;
      s_r.em_st <= EM_OFF;
      s_r.sync_st <= SY_OUT;
      s_r.link_st <= LINK_DEACTIVATED;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign ser_clk_o = s_r.ser_clk_out;
  assign dsl_clk_o = s_r.dsl_clk_out;
  assign clk_mode_o = s_r.clk_mode;
  assign clk_invalid_o = s_r.clk_invalid;
  assign local_loop_o = s_r.loc_loop;
  assign remote_loop_o = s_r.rem_loop;
  assign if_e1_o = s_r.if_e1;
  assign mgmt_addr_o = s_r.mgmt_addr;
  assign mgmt_active_o = s_r.mgmt_active;
  assign reset_mode_o = s_r.reset_mode;
  assign console_baud_div_o = s_r.baud_div;
  assign timeslots_o = s_r.timeslots;
  assign dsl_link_enable_o = s_r.link_en;
  assign dsl_restart_o = s_r.restart;
  assign sync_state_o = sync_code(s_r.sync_st);
  assign link_state_o = s_r.link_st;

endmodule // mcs_top

// ==== mcs_assertions.sv ====
`timescale 1ns/1ps
module mcs_assertions
  import mcs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire mcs_pins_t pins_i,
  input wire logic ser_clk_o,
  input wire logic dsl_clk_o,
  input wire mcs_clk_mode_t clk_mode_o,
  input wire logic clk_invalid_o,
  input wire logic local_loop_o,
  input wire logic remote_loop_o,
  input wire logic if_e1_o,
  input wire logic [7:0] mgmt_addr_o,
  input wire logic mgmt_active_o,
  input wire logic reset_mode_o,
  input wire logic [15:0] console_baud_div_o,
  input wire logic dsl_restart_o
);
  logic [35:0] cfg;
  // The link clocks are left out so that settled switches can be told apart.
  assign cfg = {pins_i.sw1, pins_i.sw2, pins_i.sw3, pins_i.local_loop_request,
    pins_i.remote_loop_request, pins_i.eth_variant, pins_i.chassis_addr,
    pins_i.chassis_sel};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_still;
    $stable(cfg)[*6];
  endsequence
  property p_mode;
    s_still |-> clk_mode_o == {pins_i.sw2[SW_CLK_B], pins_i.sw2[SW_CLK_A]};
  endproperty
  property p_eth;
    s_still ##0 (pins_i.eth_variant && clk_mode_o == CLK_EXTERNAL)
      |-> clk_invalid_o;
  endproperty
  property p_int;
    (clk_mode_o == CLK_INTERNAL && !clk_invalid_o)[*4]
      |-> ser_clk_o == dsl_clk_o;
  endproperty
  property p_ext;
    (clk_mode_o == CLK_EXTERNAL && !clk_invalid_o)[*4]
      |-> dsl_clk_o == $past(pins_i.ser_clk, 3);
  endproperty
  property p_rec;
    (clk_mode_o == CLK_RECOVER)[*4] |-> ser_clk_o == $past(pins_i.dsl_rx_clk, 3);
  endproperty
  property p_loop;
    s_still |-> local_loop_o == (pins_i.local_loop_request &&
      !pins_i.sw2[SW_LOOPS]) && remote_loop_o ==
      (pins_i.remote_loop_request && !pins_i.sw2[SW_LOOPS]);
  endproperty
  property p_if;
    s_still |-> if_e1_o == !pins_i.sw2[SW_IFTYPE];
  endproperty
  property p_addr;
    s_still |-> mgmt_addr_o == pins_i.sw3;
  endproperty
  property p_sel;
    s_still ##0 !reset_mode_o |-> mgmt_active_o ==
      (pins_i.chassis_sel && pins_i.chassis_addr == pins_i.sw3);
  endproperty
  property p_rmode;
    reset_mode_o[*2] |-> mgmt_active_o;
  endproperty
  property p_baud;
    $stable(reset_mode_o)[*2] |-> console_baud_div_o ==
      (reset_mode_o ? BAUD_DIV_RESET : BAUD_DIV_NORMAL);
  endproperty
  property p_rst;
    dsl_restart_o |=> !dsl_restart_o;
  endproperty
  a_mode: assert property (p_mode) else $error("clock mode decode wrong");
  a_eth: assert property (p_eth) else $error("external not invalid");
  a_int: assert property (p_int) else $error("internal clocks differ");
  a_ext: assert property (p_ext) else $error("line clock not serial");
  a_rec: assert property (p_rec) else $error("serial clock not rx");
  a_loop: assert property (p_loop) else $error("loop request wrong");
  a_if: assert property (p_if) else $error("interface type wrong");
  a_addr: assert property (p_addr) else $error("address wrong");
  a_sel: assert property (p_sel) else $error("selection wrong");
  a_rmode: assert property (p_rmode) else $error("not active");
  a_baud: assert property (p_baud) else $error("baud wrong");
  a_rst: assert property (p_rst) else $error("restart too long");
endmodule // mcs_assertions

// ==== mcs_far.sv ====
`timescale 1ns/1ps
module mcs_far
  import mcs_pkg::*;
(
  input wire logic pclk,
  output logic ser_clk,
  output logic dsl_rx_clk,
  output mcs_dsl_t dsl
);
  logic [7:0] evt;
  logic fnd, bad, trn, lnk;
  assign dsl = {evt, fnd, bad, trn, lnk};
  initial
  begin
    {ser_clk, dsl_rx_clk, evt, fnd, bad, trn, lnk} = '0;
  end
  // Odd offsets keep both line clocks out of phase with pclk and each other.
  initial
  begin
    #3;
    forever #80 ser_clk = ~ser_clk;
  end
  initial
  begin
    #37;
    forever #80 dsl_rx_clk = ~dsl_rx_clk;
  end
  task automatic send(input logic [7:0] e, input logic f, input logic b);
    @(posedge pclk);
    evt <= e;
    fnd <= f;
    bad <= b;
    @(posedge pclk);
    evt <= '0;
    fnd <= 1'b0;
    bad <= 1'b0;
  endtask
  task automatic line(input logic t, input logic l);
    @(posedge pclk);
    trn <= t;
    lnk <= l;
  endtask
endmodule // mcs_far

// ==== modem_config_clock_select_tb.sv ====
`timescale 1ns/1ps
module modem_config_clock_select_tb
  import mcs_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  mcs_pins_t cfg, pins;
  mcs_dsl_t dsl;
  logic ser_clk, dsl_rx_clk, ser_o, dsl_o, inv_o, lloop_o, rloop_o, e1_o;
  logic act_o, rmode_o, len_o, rst_o;
  logic [7:0] addr_o;
  logic [15:0] baud_o;
  logic [6:0] ts_o;
  logic [1:0] sync_o;
  mcs_clk_mode_t mode_o;
  mcs_link_t link_o;
  int n_errors, n_tests, n_rst, cycles;
  logic [11:0] ra [7] = '{OFS_CTRL, OFS_TIMESLOTS, OFS_EM_MAXERR,
    OFS_EM_INTTIME, OFS_EM_INTCNT, OFS_EM_TOTINT, OFS_EM_DELAY};
  logic [31:0] rv [7] = '{1, 1, 0, 1, 1, 0, 0};
  logic [31:0] mx [5] = '{2, 3, 0, 2, 2};
  logic [31:0] dl [5] = '{1, 1, 1, 1, 20};
  logic [31:0] nr [5] = '{1, 0, 0, 0, 0};
  always_comb
  begin
    pins = cfg;
    pins.ser_clk = ser_clk;
    pins.dsl_rx_clk = dsl_rx_clk;
  end
  mcs_far far (.pclk(pclk), .ser_clk(ser_clk), .dsl_rx_clk(dsl_rx_clk),
    .dsl(dsl));
  mcs_top #(.SEC_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_i(pins), .dsl_i(dsl), .ser_clk_o(ser_o), .dsl_clk_o(dsl_o),
    .clk_mode_o(mode_o), .clk_invalid_o(inv_o), .local_loop_o(lloop_o),
    .remote_loop_o(rloop_o), .if_e1_o(e1_o), .mgmt_addr_o(addr_o),
    .mgmt_active_o(act_o), .reset_mode_o(rmode_o),
    .console_baud_div_o(baud_o), .timeslots_o(ts_o),
    .dsl_link_enable_o(len_o), .dsl_restart_o(rst_o),
    .sync_state_o(sync_o), .link_state_o(link_o));
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (rst_o === 1'b1)
      n_rst++;
    if (cycles == 20000)
    begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready is a flop, so its mid-cycle value is what the next edge sees.
    do
      @(negedge pclk);
    while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rd_v, e);
  endtask
  task automatic send_sync(input int n, input logic f, input logic [1:0] e);
    repeat (n) far.send(8'h00, f, !f);
    cyc(2);
    chk(sync_o, e);
  endtask
  initial
  begin
    {n_errors, n_tests, n_rst, cycles} = '0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    cfg = '0;
    presetn = 1'b0;
    cyc(12);
    chk(link_o, LINK_DEACTIVATED);
    presetn <= 1'b1;
    cyc(8);
    chk(baud_o, BAUD_DIV_NORMAL);
    foreach (ra[i]) rd(ra[i], rv[i]);
    apb(1'b0, 12'h03c, '0);
    chk(er_v, 1'b1);
    // Each clock switch setting is tried with and without the Ethernet variant.
    for (int m = 0; m < 8; m++)
    begin
      cfg.sw2[SW_CLK_A] <= m[0];
      cfg.sw2[SW_CLK_B] <= m[1];
      cfg.eth_variant <= m[2];
      cyc(8);
      chk(mode_o, m[1:0]);
      chk(inv_o, m[1:0] == 2'h3 || m == 5);
    end
    cfg.sw2 <= 8'h00;
    cfg.eth_variant <= 1'b0;
    cfg.local_loop_request <= 1'b1;
    cyc(8);
    chk({lloop_o, rloop_o, e1_o}, 3'b101);
    cfg.sw2 <= 8'h60;
    cfg.remote_loop_request <= 1'b1;
    cyc(8);
    chk({lloop_o, rloop_o, e1_o}, 3'b000);
    cfg.sw2 <= 8'h00;
    cfg.sw3 <= 8'ha5;
    cfg.chassis_addr <= 8'ha5;
    cfg.chassis_sel <= 1'b1;
    cyc(8);
    chk({lloop_o, rloop_o, addr_o, act_o}, {2'b11, 8'ha5, 1'b1});
    cfg.chassis_addr <= 8'h5a;
    cyc(8);
    chk(act_o, 1'b0);
    apb(1'b1, OFS_TIMESLOTS, 32'h48);
    cyc(2);
    chk(ts_o, 7'h48);
    far.line(1'b1, 1'b0);
    cyc(3);
    chk(link_o, LINK_IN_PROGRESS);
    apb(1'b1, OFS_CTRL, 32'h3);
    send_sync(1, 1'b1, 2'h1);
    send_sync(3, 1'b1, 2'h2);
    send_sync(1, 1'b0, 2'h3);
    send_sync(1, 1'b1, 2'h2);
    send_sync(5, 1'b0, 2'h0);
    rd(OFS_CNT_BASE + 12'h004, 32'h1);
    far.send(8'h81, 1'b0, 1'b0);
    rd(OFS_CNT_BASE, 32'h1);
    rd(OFS_CNT_BASE + 12'h020, 32'h1);
    far.line(1'b0, 1'b1);
    cyc(3);
    chk(link_o, LINK_SUCCESS);
    apb(1'b1, OFS_EM_INTCNT, 32'h2);
    for (int r = 0; r < 5; r++)
    begin
      apb(1'b1, OFS_EM_MAXERR, mx[r]);
      apb(1'b1, OFS_EM_TOTINT, r == 3);
      apb(1'b1, OFS_EM_DELAY, dl[r]);
      far.line(1'b0, 1'b0);
      cyc(3);
      chk(link_o, LINK_IDLE);
      n_rst = 0;
      far.line(1'b0, 1'b1);
      repeat (30)
      begin
        far.send(8'h01, 1'b0, 1'b0);
        cyc(8);
      end
      chk(n_rst, nr[r]);
    end
    cfg.sw1 <= 8'hff;
    cfg.sw2 <= 8'hff;
    cfg.sw3 <= 8'hff;
    presetn <= 1'b0;
    cyc(3);
    presetn <= 1'b1;
    cyc(10);
    chk({rmode_o, act_o}, 2'b11);
    chk(baud_o, BAUD_DIV_RESET);
    stop_test();
  end
endmodule // modem_config_clock_select_tb

bind mcs_top mcs_assertions chk_i (.pclk(pclk), .presetn(presetn),
  .pins_i(pins_i), .ser_clk_o(ser_clk_o), .dsl_clk_o(dsl_clk_o),
  .clk_mode_o(clk_mode_o), .clk_invalid_o(clk_invalid_o),
  .local_loop_o(local_loop_o), .remote_loop_o(remote_loop_o),
  .if_e1_o(if_e1_o), .mgmt_addr_o(mgmt_addr_o),
  .mgmt_active_o(mgmt_active_o), .reset_mode_o(reset_mode_o),
  .console_baud_div_o(console_baud_div_o), .dsl_restart_o(dsl_restart_o));
